/* hw/sram_pkg.sv */
// Shared constants and types for the burst-of-two DDR static memory port.
// Assumes one 200 MHz clock; each clock cycle is one half of the memory's
// input clock period, so the memory clocks run at 100 MHz.
package sram_pkg;

    // ----------------------------------------------------------------
    // Organisation
    // ----------------------------------------------------------------
    localparam int LANE_W = 9;
    localparam int DW_NARROW = 18;
    localparam int DW_WIDE = 36;
    localparam int AW_NARROW = 22;
    localparam int AW_WIDE = 21;
    localparam int BURST_LEN = 2;

    // ----------------------------------------------------------------
    // Timing, in clock cycles of the 5 ns clock
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    // Host sees read beat 0 and 1 this many cycles after load reaches pins.
    localparam int RD_BEAT0_AT = 3;
    localparam int RD_BEAT1_AT = 4;
    // Reads that may be in flight while the response buffer is checked.
    localparam int RD_INFLIGHT = 3;
    localparam int FIFO_DEPTH = 16;

    localparam logic RW_READ = 1'b1;
    localparam logic DRIVE_ON = 1'b0;
    localparam logic DRIVE_OFF = 1'b1;

    typedef enum logic [1:0] {
        OUT_IDLE = 2'b00,
        OUT_BEAT0 = 2'b01,
        OUT_BEAT1 = 2'b11
    } outState_t;

    function automatic int dataWidth(bit wide36);
        return wide36 ? DW_WIDE : DW_NARROW;
    endfunction

    function automatic int addrWidth(bit wide36);
        return wide36 ? AW_WIDE : AW_NARROW;
    endfunction

endpackage

/* hw/sram_if.sv */
// Pin bundle between the external memory controller and the memory.
// The complementary clocks are the inverse of k and c; the shared data
// pins are resolved here from the two output enables.
interface sram_if #(
    parameter bit WIDE36 = 1'b0
);
    localparam int DW = sram_pkg::dataWidth(WIDE36);
    localparam int AW = sram_pkg::addrWidth(WIDE36);
    localparam int NB = DW / sram_pkg::LANE_W;

    logic k;
    logic c;
    logic load_strobe_n;
    logic rwSel;
    logic [AW-1:1] addrHigh;
    logic burst_start_bit;
    logic [NB-1:0] byte_write_select_n;
    logic [DW-1:0] hostDq;
    logic hostDqOe_n;
    logic [DW-1:0] devDq;
    logic devDqOe_n;
    logic [DW-1:0] dqBus;

    assign dqBus = !devDqOe_n ? devDq : (!hostDqOe_n ? hostDq : '0);

    modport device (
        input k, c, load_strobe_n, rwSel, addrHigh, burst_start_bit,
        input byte_write_select_n, dqBus,
        output devDq, devDqOe_n
    );

    modport host (
        output k, c, load_strobe_n, rwSel, addrHigh, burst_start_bit,
        output byte_write_select_n, hostDq, hostDqOe_n,
        input dqBus
    );
endinterface

/* hw/sram_device.sv */
// Memory end of the DDR burst-of-two static memory port.
// Assumes the controller runs on the same clk and changes the pins only
// from flip-flops, so the pins are read without synchronisers.
//
// How it works
// - write word captured on K and K-bar rises.
// - read words driven on C and C-bar rises, or K and K-bar.
// - data drivers released when no read selected.
// - 18-bit or 36-bit organisation, one array per nine-bit lane.
// - controller pulls load low with address, direction.
// - every access moves exactly two words.
// - byte selects sampled with the data word.
// - byte select n gates nine-bit lane n.
// - deselected lane keeps its stored byte.
// - low address bit seeds linear burst counter.
// - address 22 bits narrow, 21 bits wide.
// - one address bus serves reads and writes.
// - address ignored while port is deselected.
// - read/write select high reads, low writes.
// - controller supplies output clock pair, may skew.
// - every access starts on a K rise.
module sram_device #(
    parameter bit WIDE36 = 1'b0,
    parameter int MEM_AW = sram_pkg::addrWidth(WIDE36)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Strap
    input wire logic singleClockMode,
    // Memory pins
    sram_if.device link
);
    import sram_pkg::*;

    localparam int DW = dataWidth(WIDE36);
    localparam int AW = addrWidth(WIDE36);
    localparam int NB = DW / LANE_W;
    localparam int MEM_DEPTH = 2 ** MEM_AW;

    // ----------------------------------------------------------------
    // Clock edges
    // ----------------------------------------------------------------
    logic kPrev_q;
    logic kPrev_d;
    logic ocPrev_q;
    logic ocPrev_d;
    logic outClk;
    logic kRise;
    logic kbRise;
    logic ocRise;
    logic ocbRise;
    logic load;

    // In single clock mode the input pair also times the read data.
    assign outClk = singleClockMode ? link.k : link.c;
    assign kRise = link.k && !kPrev_q;
    assign kbRise = !link.k && kPrev_q;
    assign ocRise = outClk && !ocPrev_q;
    assign ocbRise = !outClk && ocPrev_q;
    // Address and direction count only on a K rise with load low.
    assign load = kRise && !link.load_strobe_n;

    always_comb begin
        kPrev_d = link.k;
        ocPrev_d = outClk;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            kPrev_q <= 1'b0;
            ocPrev_q <= 1'b0;
        end else begin
            kPrev_q <= kPrev_d;
            ocPrev_q <= ocPrev_d;
        end
    end

    // ----------------------------------------------------------------
    // Write path
    // ----------------------------------------------------------------
    logic wrPend_q;
    logic wrPend_d;
    logic [AW-1:1] wrPendBase_q;
    logic [AW-1:1] wrPendBase_d;
    logic wrPendCtr_q;
    logic wrPendCtr_d;
    logic wrAct_q;
    logic wrAct_d;
    logic [AW-1:1] wrBase_q;
    logic [AW-1:1] wrBase_d;
    logic wrCtr_q;
    logic wrCtr_d;
    logic wrEn;
    logic [AW-1:0] wrAddr;

    always_comb begin
        wrPend_d = wrPend_q;
        wrPendBase_d = wrPendBase_q;
        wrPendCtr_d = wrPendCtr_q;
        wrAct_d = wrAct_q;
        wrBase_d = wrBase_q;
        wrCtr_d = wrCtr_q;
        wrEn = 1'b0;
        wrAddr = {wrBase_q, wrCtr_q};
        if (kRise) begin
            wrPend_d = 1'b0;
            if (wrPend_q) begin
                wrEn = 1'b1;
                wrAddr = {wrPendBase_q, wrPendCtr_q};
                wrAct_d = 1'b1;
                wrBase_d = wrPendBase_q;
                wrCtr_d = 1'(wrPendCtr_q + 1'b1);
            end
            if (load && link.rwSel != RW_READ) begin
                wrPend_d = 1'b1;
                wrPendBase_d = link.addrHigh;
                wrPendCtr_d = link.burst_start_bit;
            end
        end else if (kbRise && wrAct_q) begin
            wrEn = 1'b1;
            wrAct_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            wrPendBase_q <= '0;
            wrPendCtr_q <= 1'b0;
            wrAct_q <= 1'b0;
            wrBase_q <= '0;
            wrCtr_q <= 1'b0;
        end else begin
            wrPend_q <= wrPend_d;
            wrPendBase_q <= wrPendBase_d;
            wrPendCtr_q <= wrPendCtr_d;
            wrAct_q <= wrAct_d;
            wrBase_q <= wrBase_d;
            wrCtr_q <= wrCtr_d;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    outState_t outState_q;
    outState_t outState_d;
    logic rdPend_q;
    logic rdPend_d;
    logic [AW-1:1] rdPendBase_q;
    logic [AW-1:1] rdPendBase_d;
    logic rdPendCtr_q;
    logic rdPendCtr_d;
    logic [AW-1:1] rdBase_q;
    logic [AW-1:1] rdBase_d;
    logic rdCtr_q;
    logic rdCtr_d;
    logic [AW-1:0] rdAddr;
    logic [DW-1:0] rdWord;
    logic [DW-1:0] devDq_q;
    logic [DW-1:0] devDq_d;
    logic devDqOe_n_q;
    logic devDqOe_n_d;

    // A read loaded on the same K rise as an output clock rise waits for
    // the next one; that gives one full period of access latency.
    always_comb begin
        outState_d = outState_q;
        rdPend_d = rdPend_q;
        rdPendBase_d = rdPendBase_q;
        rdPendCtr_d = rdPendCtr_q;
        rdBase_d = rdBase_q;
        rdCtr_d = rdCtr_q;
        devDq_d = devDq_q;
        devDqOe_n_d = devDqOe_n_q;
        rdAddr = {rdPendBase_q, rdPendCtr_q};
        if (ocRise) begin
            rdPend_d = 1'b0;
            if (rdPend_q) begin
                outState_d = OUT_BEAT0;
                devDq_d = rdWord;
                devDqOe_n_d = DRIVE_ON;
                rdBase_d = rdPendBase_q;
                rdCtr_d = 1'(rdPendCtr_q + 1'b1);
            end else begin
                outState_d = OUT_IDLE;
                devDqOe_n_d = DRIVE_OFF;
            end
        end else if (ocbRise) begin
            case (outState_q)
                OUT_BEAT0: begin
                    rdAddr = {rdBase_q, rdCtr_q};
                    outState_d = OUT_BEAT1;
                    devDq_d = rdWord;
                end
                OUT_BEAT1: begin
                    outState_d = OUT_BEAT1;
                end
                OUT_IDLE: begin
                    devDqOe_n_d = DRIVE_OFF;
                end
                default: begin
                    outState_d = OUT_IDLE;
                    devDqOe_n_d = DRIVE_OFF;
                end
            endcase
        end
        if (load && link.rwSel == RW_READ) begin
            rdPend_d = 1'b1;
            rdPendBase_d = link.addrHigh;
            rdPendCtr_d = link.burst_start_bit;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outState_q <= OUT_IDLE;
            rdPend_q <= 1'b0;
            rdPendBase_q <= '0;
            rdPendCtr_q <= 1'b0;
            rdBase_q <= '0;
            rdCtr_q <= 1'b0;
            devDq_q <= '0;
            devDqOe_n_q <= DRIVE_OFF;
        end else begin
            outState_q <= outState_d;
            rdPend_q <= rdPend_d;
            rdPendBase_q <= rdPendBase_d;
            rdPendCtr_q <= rdPendCtr_d;
            rdBase_q <= rdBase_d;
            rdCtr_q <= rdCtr_d;
            devDq_q <= devDq_d;
            devDqOe_n_q <= devDqOe_n_d;
        end
    end

    assign link.devDq = devDq_q;
    assign link.devDqOe_n = devDqOe_n_q;

    // ----------------------------------------------------------------
    // Storage, one array per nine-bit lane
    // ----------------------------------------------------------------
    // Splitting the array by lane lets each byte select gate its own
    // write port without a read-modify-write of the whole word.
    for (genvar g = 0; g < NB; g++) begin : gLane
        logic [LANE_W-1:0] laneMem [MEM_DEPTH];

        always_ff @(posedge clk) begin
            if (wrEn && !link.byte_write_select_n[g]) begin
                laneMem[wrAddr[MEM_AW-1:0]] <=
                    link.dqBus[g*LANE_W +: LANE_W];
            end
        end

        assign rdWord[g*LANE_W +: LANE_W] = laneMem[rdAddr[MEM_AW-1:0]];
    end

endmodule // sram_device

/* hw/sram_host.sv */
// Controller end of the DDR burst-of-two static memory port, with the
// response buffer it fills. Assumes the memory shares clk; k and c are
// made here by halving clk, so they are no second clock domain.
module sram_rsp_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] wrPtr_d;
    logic [PW-1:0] rdPtr_q;
    logic [PW-1:0] rdPtr_d;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic push;
    logic pop;
    logic valid_q;
    logic valid_d;

    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        wrPtr_d = push ? PW'(wrPtr_q + 1'b1) : wrPtr_q;
        rdPtr_d = pop ? PW'(rdPtr_q + 1'b1) : rdPtr_q;
        count_d = CW'(count_q + CW'(push) - CW'(pop));
        // Registered so the drain side sees valid straight from a flop.
        valid_d = count_d != '0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            valid_q <= 1'b0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            valid_q <= valid_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    assign inReady = count_q != CW'(DEPTH);
    assign outValid = valid_q;
    assign outData = mem[rdPtr_q];
    assign level = count_q;
endmodule // sram_rsp_fifo

module sram_host #(
    parameter bit WIDE36 = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqRead,
    input wire logic [sram_pkg::addrWidth(WIDE36)-1:0] reqAddr,
    input wire logic [sram_pkg::dataWidth(WIDE36)-1:0] reqWord0,
    input wire logic [sram_pkg::dataWidth(WIDE36)-1:0] reqWord1,
    input wire logic
        [sram_pkg::dataWidth(WIDE36)/sram_pkg::LANE_W-1:0] reqLane0_n,
    input wire logic
        [sram_pkg::dataWidth(WIDE36)/sram_pkg::LANE_W-1:0] reqLane1_n,
    // Read response
    output logic rspValid,
    input wire logic rspReady,
    output logic [sram_pkg::dataWidth(WIDE36)-1:0] rspWord0,
    output logic [sram_pkg::dataWidth(WIDE36)-1:0] rspWord1,
    // Memory pins
    sram_if.host link
);
    import sram_pkg::*;

    localparam int DW = dataWidth(WIDE36);
    localparam int AW = addrWidth(WIDE36);
    localparam int NB = DW / LANE_W;
    localparam int CW = $clog2(FIFO_DEPTH+1);

    // ----------------------------------------------------------------
    // Request side and pins
    // ----------------------------------------------------------------
    logic k_q, k_d, reqReady_q, reqReady_d, lastRead_q, lastRead_d;
    logic load_n_q, load_n_d, rw_q, rw_d, bit0_q, bit0_d;
    logic [AW-1:1] addr_q, addr_d;
    logic wrPend_q, wrPend_d, beat1Due_q, beat1Due_d, oe_n_q, oe_n_d;
    logic [DW-1:0] pend0_q, pend0_d, pend1_q, pend1_d;
    logic [DW-1:0] beat1_q, beat1_d, dq_q, dq_d;
    logic [NB-1:0] pendL0_q, pendL0_d, pendL1_q, pendL1_d;
    logic [NB-1:0] beat1L_q, beat1L_d, lane_q, lane_d;
    logic [RD_BEAT1_AT:0] rdShift_q, rdShift_d;
    logic [DW-1:0] cap0_q, cap0_d;
    logic issueSlot, take, push, room;
    logic [CW-1:0] level;

    // The next cycle carries a K rise, so pins set now are sampled there.
    assign issueSlot = !k_q;
    assign take = issueSlot && reqReady_q && reqValid;
    assign push = rdShift_q[RD_BEAT1_AT];
    assign room = 32'(level) + RD_INFLIGHT <= FIFO_DEPTH;

    always_comb begin
        k_d = !k_q;
        load_n_d = 1'b1;
        rw_d = rw_q;
        addr_d = addr_q;
        bit0_d = bit0_q;
        wrPend_d = wrPend_q;
        pend0_d = pend0_q;
        pend1_d = pend1_q;
        pendL0_d = pendL0_q;
        pendL1_d = pendL1_q;
        beat1Due_d = 1'b0;
        beat1_d = beat1_q;
        beat1L_d = beat1L_q;
        dq_d = dq_q;
        lane_d = lane_q;
        oe_n_d = DRIVE_OFF;
        lastRead_d = lastRead_q;
        // One idle slot after each read turns the data bus around.
        reqReady_d = k_q && room && !lastRead_q;
        if (issueSlot) begin
            load_n_d = !take;
            lastRead_d = take && reqRead;
            if (take) begin
                rw_d = reqRead;
                addr_d = reqAddr[AW-1:1];
                bit0_d = reqAddr[0];
            end
            if (wrPend_q) begin
                dq_d = pend0_q;
                lane_d = pendL0_q;
                oe_n_d = DRIVE_ON;
                beat1Due_d = 1'b1;
                beat1_d = pend1_q;
                beat1L_d = pendL1_q;
            end
            wrPend_d = take && !reqRead;
            if (take && !reqRead) begin
                pend0_d = reqWord0;
                pend1_d = reqWord1;
                pendL0_d = reqLane0_n;
                pendL1_d = reqLane1_n;
            end
        end else if (beat1Due_q) begin
            dq_d = beat1_q;
            lane_d = beat1L_q;
            oe_n_d = DRIVE_ON;
        end
        rdShift_d = {rdShift_q[RD_BEAT1_AT-1:0], take && reqRead};
        cap0_d = rdShift_q[RD_BEAT0_AT] ? link.dqBus : cap0_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            k_q <= 1'b0;
            reqReady_q <= 1'b0;
            lastRead_q <= 1'b0;
            load_n_q <= 1'b1;
            rw_q <= RW_READ;
            addr_q <= '0;
            bit0_q <= 1'b0;
            wrPend_q <= 1'b0;
            pend0_q <= '0;
            pend1_q <= '0;
            pendL0_q <= '1;
            pendL1_q <= '1;
            beat1Due_q <= 1'b0;
            beat1_q <= '0;
            beat1L_q <= '1;
            dq_q <= '0;
            lane_q <= '1;
            oe_n_q <= DRIVE_OFF;
            rdShift_q <= '0;
            cap0_q <= '0;
        end else begin
            k_q <= k_d;
            reqReady_q <= reqReady_d;
            lastRead_q <= lastRead_d;
            load_n_q <= load_n_d;
            rw_q <= rw_d;
            addr_q <= addr_d;
            bit0_q <= bit0_d;
            wrPend_q <= wrPend_d;
            pend0_q <= pend0_d;
            pend1_q <= pend1_d;
            pendL0_q <= pendL0_d;
            pendL1_q <= pendL1_d;
            beat1Due_q <= beat1Due_d;
            beat1_q <= beat1_d;
            beat1L_q <= beat1L_d;
            dq_q <= dq_d;
            lane_q <= lane_d;
            oe_n_q <= oe_n_d;
            rdShift_q <= rdShift_d;
            cap0_q <= cap0_d;
        end
    end

    // The output clock pair follows K with no skew.
    assign link.k = k_q;
    assign link.c = k_q;
    assign link.load_strobe_n = load_n_q;
    assign link.rwSel = rw_q;
    assign link.addrHigh = addr_q;
    assign link.burst_start_bit = bit0_q;
    assign link.byte_write_select_n = lane_q;
    assign link.hostDq = dq_q;
    assign link.hostDqOe_n = oe_n_q;
    assign reqReady = reqReady_q;

    // ----------------------------------------------------------------
    // Response buffer
    // ----------------------------------------------------------------
    logic [2*DW-1:0] fifoOut;

    sram_rsp_fifo #(
        .WIDTH(2*DW),
        .DEPTH(FIFO_DEPTH)
    ) uFifo (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(push),
        .inReady(),
        .inData({link.dqBus, cap0_q}),
        .outValid(rspValid),
        .outReady(rspReady),
        .outData(fifoOut),
        .level(level)
    );

    assign rspWord0 = fifoOut[DW-1:0];
    assign rspWord1 = fifoOut[2*DW-1:DW];
endmodule // sram_host

/* verif/sram_link_properties.sv */
// Assertions on the pins between the controller and the memory end.
// Assumes both ends run on clk and every pin is a flop of that clock.
module sram_link_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Memory pins
    input wire logic k,
    input wire logic c,
    input wire logic load_strobe_n,
    input wire logic rwSel,
    input wire logic hostDqOe_n,
    input wire logic devDqOe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rdLoad;
    logic wrLoad;
    assign rdLoad = !load_strobe_n && rwSel;
    assign wrLoad = !load_strobe_n && !rwSel;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_rdBeats;
        !devDqOe_n [*2] ##1 devDqOe_n;
    endsequence
    sequence s_wrBeats;
        !hostDqOe_n [*2];
    endsequence

    property p_load_on_k_rise;
        !load_strobe_n |-> k && !$past(k);
    endproperty
    a_load_on_k_rise: assert property (p_load_on_k_rise)
        else $error("load seen outside a K rise");
    property p_k_toggle;
        $past(rst_n) |-> k != $past(k);
    endproperty
    a_k_toggle: assert property (p_k_toggle)
        else $error("input clock did not toggle");
    property p_out_clock;
        c == k;
    endproperty
    a_out_clock: assert property (p_out_clock)
        else $error("output clock differs from input clock");
    property p_load_pulse;
        !load_strobe_n |=> load_strobe_n;
    endproperty
    a_load_pulse: assert property (p_load_pulse)
        else $error("load held longer than one cycle");
    property p_read_beats;
        rdLoad |-> ##3 s_rdBeats;
    endproperty
    a_read_beats: assert property (p_read_beats)
        else $error("read did not drive exactly two beats");
    property p_write_beats;
        wrLoad |-> ##2 s_wrBeats;
    endproperty
    a_write_beats: assert property (p_write_beats)
        else $error("write did not drive two beats");
    property p_release;
        !devDqOe_n |-> $past(rdLoad, 3) || $past(rdLoad, 4);
    endproperty
    a_release: assert property (p_release)
        else $error("memory drives data with no read");
    property p_one_driver;
        !(!devDqOe_n && !hostDqOe_n);
    endproperty
    a_one_driver: assert property (p_one_driver)
        else $error("both ends drive the data bus");
    property p_read_gap;
        rdLoad |=> load_strobe_n [*3];
    endproperty
    a_read_gap: assert property (p_read_gap)
        else $error("load too soon after a read");
endmodule // sram_link_properties

/* verif/tb.sv */
// Bench joining the controller end and the memory end over one bundle.
// Assumes the hw files are compiled first; organisation is 36 bits.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sram_pkg::*;

    // For reads the two words are the expected response.
    typedef struct {
        logic rd;
        logic [20:0] a;
        logic [35:0] w0;
        logic [35:0] w1;
        logic [3:0] l0;
        logic [3:0] l1;
    } row_t;

    logic clk, rst_n, singleClockMode, reqValid, reqReady, reqRead;
    logic rspValid, rspReady;
    logic [20:0] reqAddr;
    logic [35:0] reqWord0, reqWord1, rspWord0, rspWord1;
    logic [3:0] reqLane0_n, reqLane1_n;
    int mismatches, nTests, cnt;
    bit ok;
    row_t rows [7] = '{
        '{1'b0, 21'h10, 36'h123456789, 36'habcdef012, 4'h0, 4'h0},
        '{1'b1, 21'h10, 36'h123456789, 36'habcdef012, 4'hf, 4'hf},
        '{1'b1, 21'h11, 36'habcdef012, 36'h123456789, 4'hf, 4'hf},
        '{1'b0, 21'h11, 36'h555555555, 36'h0f0f0f0f0, 4'ha, 4'h0},
        '{1'b1, 21'h10, 36'h0f0f0f0f0, 36'habd56f155, 4'hf, 4'hf},
        '{1'b0, 21'h10, 36'hfffffffff, 36'h000000000, 4'hf, 4'h5},
        '{1'b1, 21'h11, 36'h005540155, 36'h0f0f0f0f0, 4'hf, 4'hf}
    };

    sram_if #(.WIDE36(1'b1)) link ();
    sram_host #(.WIDE36(1'b1)) i_sram_host (.clk(clk), .rst_n(rst_n),
        .reqValid(reqValid), .reqReady(reqReady), .reqRead(reqRead),
        .reqAddr(reqAddr), .reqWord0(reqWord0), .reqWord1(reqWord1),
        .reqLane0_n(reqLane0_n), .reqLane1_n(reqLane1_n),
        .rspValid(rspValid), .rspReady(rspReady), .rspWord0(rspWord0),
        .rspWord1(rspWord1), .link(link));
    sram_device #(.WIDE36(1'b1), .MEM_AW(10)) i_sram_device (.clk(clk),
        .rst_n(rst_n), .singleClockMode(singleClockMode), .link(link));
    sram_link_properties i_sram_link_properties (.clk(clk), .rst_n(rst_n),
        .k(link.k), .c(link.c), .load_strobe_n(link.load_strobe_n),
        .rwSel(link.rwSel), .hostDqOe_n(link.hostDqOe_n),
        .devDqOe_n(link.devDqOe_n));

    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Checking and requests
    // ----------------------------------------------------------------
    task automatic results();
        $display("mismatches %0d comparisons %0d", mismatches, nTests);
        if (mismatches == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        mismatches++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic chkWord(input logic [35:0] got, input logic [35:0] exp);
        nTests++;
        if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
    endtask

    task automatic chkFlag(input logic got, input logic exp);
        nTests++;
        if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
    endtask

    // Holds the request until the edge that takes it, or gives up.
    task automatic issue(input row_t r, input int lim, output bit taken);
        int n;
        @(posedge clk) #1;
        reqValid = 1'b1;
        reqRead = r.rd;
        reqAddr = r.a;
        reqWord0 = r.w0;
        reqWord1 = r.w1;
        reqLane0_n = r.l0;
        reqLane1_n = r.l1;
        n = 0;
        while (reqReady !== 1'b1 && n < lim) begin
            @(posedge clk) #1;
            n++;
        end
        taken = (reqReady === 1'b1);
        if (taken) @(posedge clk) #1;
        reqValid = 1'b0;
    endtask

    task automatic req(input row_t r);
        bit taken;
        issue(r, 40, taken);
        if (!taken) begin
            fail("request not taken");
            results();
        end
    endtask

    task automatic getRsp(input logic [35:0] e0, input logic [35:0] e1);
        int n;
        n = 0;
        while (rspValid !== 1'b1 && n < 40) begin
            @(posedge clk) #1;
            n++;
        end
        if (rspValid !== 1'b1) begin
            fail("no read response");
            results();
        end
        chkWord(rspWord0, e0);
        chkWord(rspWord1, e1);
        @(posedge clk) #1;
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        singleClockMode = 1'b0;
        reqValid = 1'b0;
        reqRead = 1'b0;
        reqAddr = '0;
        reqWord0 = '0;
        reqWord1 = '0;
        reqLane0_n = '1;
        reqLane1_n = '1;
        rspReady = 1'b1;
        mismatches = 0;
        nTests = 0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int m = 0; m < 2; m++) begin
            singleClockMode = m[0];
            foreach (rows[i]) begin
                req(rows[i]);
                if (rows[i].rd) getRsp(rows[i].w0, rows[i].w1);
            end
        end
        req(row_t'{1'b0, 21'h20, 36'h111111111, 36'h222222222, 4'h0,
            4'h0});
        req(row_t'{1'b0, 21'h22, 36'h333333333, 36'h444444444, 4'h0,
            4'h0});
        // Stall the drain side so the response buffer fills until the room check holds reads off.
        rspReady = 1'b0;
        cnt = 0;
        ok = 1'b1;
        while (ok && cnt < 20) begin
            issue(row_t'{1'b1, 21'h20, 36'h0, 36'h0, 4'hf, 4'hf}, 30, ok);
            if (ok) cnt++;
        end
        chkFlag(cnt >= 14 && cnt <= FIFO_DEPTH, 1'b1);
        rspReady = 1'b1;
        repeat (cnt) getRsp(36'h111111111, 36'h222222222);
        chkFlag(rspValid, 1'b0);
        // Reset lands in mid-read; the array keeps its content.
        req(row_t'{1'b1, 21'h22, 36'h0, 36'h0, 4'hf, 4'hf});
        repeat (3) @(posedge clk);
        #1 chkFlag(link.devDqOe_n, DRIVE_ON);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 chkFlag(link.devDqOe_n, DRIVE_OFF);
        chkFlag(link.load_strobe_n, 1'b1);
        chkFlag(reqReady, 1'b0);
        chkFlag(rspValid, 1'b0);
        rst_n = 1'b1;
        req(row_t'{1'b1, 21'h23, 36'h0, 36'h0, 4'hf, 4'hf});
        getRsp(36'h444444444, 36'h333333333);
        results();
    end
endmodule // tb
